/* File: src/cpu8_decode_params.svh */
// Opcode field codes, lengths and cycle counts for the instruction decoder.
//
// Behaviour
// RULE1: Low nibble picks the operation; high nibble A..F picks the addressing mode.
// RULE2: Read ops take 2/2 imm, 2/3 dir, 3/4 ext, 1/3 ix, 2/4 ix1, 3/5 ix2.
// RULE3: compare_index is low nibble 3; flags from index minus operand, index kept.
// RULE4: subtract_borrow is low nibble 2; accumulator minus operand minus carry.
// RULE5: add_with_carry is low nibble 9; accumulator plus operand plus carry.
// RULE6: bit_test is low nibble 5; AND sets flags only, accumulator kept.
// RULE7: Branches 0x20..0x2F are two bytes, three cycles; 20 always, 21 never.
// RULE8: Opcode 22 branches if unsigned higher, 23 if lower or same.
// RULE9: Opcode 24 branches on carry clear, 25 on carry set.
// RULE10: Opcode 28 branches on half carry clear, 29 on half carry set.
// RULE11: Opcode 2C branches on interrupt mask clear, 2D on mask set.
// RULE12: Opcode 2E branches on interrupt pin low, 2F on pin high.
// RULE13: test_one_skip for bit n is opcode 2n, three bytes, five cycles.
// RULE14: test_zero_skip is opcode 01+2n, three bytes, five cycles, taken on zero.
// RULE15: Bit test-and-branch copies the tested bit into carry.
// RULE16: Half carry reflects a carry from bit 3 into bit 4 on adds.
// RULE17: set_single_bit 0x10+2n, clear_single_bit 0x11+2n, two bytes, five cycles.
// RULE18: Stores have no immediate form and take one cycle more than loads.
// RULE19: jump_abs low nibble C, call_abs D; call_relative 0xAD, two bytes, six cycles.
`ifndef CPU8_DECODE_PARAMS_SVH
`define CPU8_DECODE_PARAMS_SVH

`define HI_BITOP 4'h0
`define HI_BITSC 4'h1
`define HI_REL 4'h2
`define HI_IMM 4'ha
`define HI_DIR 4'hb
`define HI_EXT 4'hc
`define HI_IX2 4'hd
`define HI_IX1 4'he
`define HI_IX 4'hf

`define OPC_CALL_REL 8'had
`define OPC_REL_ALWAYS 8'h20
`define OPC_REL_NEVER 8'h21

`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3

`define CYC_IMM 4'h2
`define CYC_DIR 4'h3
`define CYC_EXT 4'h4
`define CYC_IX 4'h3
`define CYC_IX1 4'h4
`define CYC_IX2 4'h5
`define CYC_STORE_EXTRA 4'h1
`define CYC_JUMP_LESS 4'h1
`define CYC_CALL_EXTRA 4'h2
`define CYC_REL 4'h3
`define CYC_CALL_REL 4'h6
`define CYC_BIT 4'h5

`endif

/* File: src/cpu8_decode_pkg.sv */
// Types shared by the instruction decoder.
package cpu8_decode_pkg;

  typedef enum logic [3:0] {
    MODE_NONE, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX2, MODE_IX1, MODE_IX,
    MODE_REL, MODE_BTB, MODE_BSC
  } mode_t;

  typedef enum logic [4:0] {
    OP_NONE, OP_SUB, OP_CMP, OP_SBC, OP_CPX, OP_AND, OP_BIT, OP_LDA, OP_STA,
    OP_EOR, OP_ADC, OP_ORA, OP_ADD, OP_JMP, OP_JSR, OP_LDX, OP_STX,
    OP_CALL_REL, OP_BRANCH, OP_TEST_ONE, OP_TEST_ZERO, OP_SET_BIT, OP_CLR_BIT
  } oper_t;

endpackage : cpu8_decode_pkg

/* File: src/cpu8_opcode_decode_timing.sv */
// Opcode decoder with length, cycle count, branch decision and ALU result.
`timescale 1ns/10ps
`include "cpu8_decode_params.svh"

module cpu8_opcode_decode_timing (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Instruction and operand
  input wire logic op_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand_i,
  // Core register state
  input wire logic [7:0] acc_i,
  input wire logic [7:0] idx_i,
  input wire logic flag_half_i,
  input wire logic flag_mask_i,
  input wire logic flag_neg_i,
  input wire logic flag_zero_i,
  input wire logic flag_carry_i,
  // External interrupt pin
  input wire logic irq_pin_i,
  // Decode result
  output logic dec_valid_o,
  output logic [7:0] opcode_o,
  output logic supported_o,
  output cpu8_decode_pkg::mode_t mode_o,
  output cpu8_decode_pkg::oper_t oper_o,
  output logic [1:0] length_o,
  output logic [3:0] cycles_o,
  output logic branch_taken_o,
  // Data result and write enables
  output logic [7:0] result_o,
  output logic acc_wr_o,
  output logic idx_wr_o,
  output logic mem_wr_o,
  // Flags, write mask order is half, negative, zero, carry
  output logic [3:0] flag_wr_o,
  output logic half_o,
  output logic neg_o,
  output logic zero_o,
  output logic carry_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {half, carry, sum}.
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [8:0] s;
    logic [4:0] lo;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {lo[4], s};
  endfunction : add8

  // Returns {borrow, difference}.
  function automatic logic [8:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    return {1'b0, a} - {1'b0, b} - {8'h00, cin};
  endfunction : sub8

  // ----------------------------------------------------------------
  // Interrupt pin synchroniser
  // ----------------------------------------------------------------
  logic irq_meta_q;
  logic irq_sync_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_meta_q <= 1'b1;
      irq_sync_q <= 1'b1;
    end else begin
      irq_meta_q <= irq_pin_i;
      irq_sync_q <= irq_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  logic [3:0] hi;
  logic [3:0] lo;
  logic ok_d;
  cpu8_decode_pkg::mode_t mode_d;
  cpu8_decode_pkg::oper_t oper_d;
  logic [1:0] len_d;
  logic [3:0] cyc_d;
  logic taken_d;
  logic [7:0] res_d;
  logic acc_wr_d;
  logic idx_wr_d;
  logic mem_wr_d;
  logic [3:0] fwr_d;
  logic h_d;
  logic c_d;
  logic [9:0] sum;
  logic [8:0] dif;
  logic tbit;

  assign hi = opcode_i[7:4];
  assign lo = opcode_i[3:0];

  always_comb begin
    ok_d = 1'b0;
    mode_d = cpu8_decode_pkg::MODE_NONE;
    oper_d = cpu8_decode_pkg::OP_NONE;
    len_d = 2'h0;
    cyc_d = 4'h0;
    taken_d = 1'b0;
    res_d = acc_i;
    acc_wr_d = 1'b0;
    idx_wr_d = 1'b0;
    mem_wr_d = 1'b0;
    fwr_d = 4'h0;
    h_d = flag_half_i;
    c_d = flag_carry_i;
    sum = 10'h000;
    dif = 9'h000;
    tbit = operand_i[opcode_i[3:1]];
    if (hi >= `HI_IMM) begin
      ok_d = 1'b1;
      unique case (hi) // RULE1
        `HI_IMM: begin
          mode_d = cpu8_decode_pkg::MODE_IMM;
          len_d = `LEN_TWO;
          cyc_d = `CYC_IMM; // RULE2
        end
        `HI_DIR: begin
          mode_d = cpu8_decode_pkg::MODE_DIR;
          len_d = `LEN_TWO;
          cyc_d = `CYC_DIR; // RULE2
        end
        `HI_EXT: begin
          mode_d = cpu8_decode_pkg::MODE_EXT;
          len_d = `LEN_THREE;
          cyc_d = `CYC_EXT; // RULE2
        end
        `HI_IX2: begin
          mode_d = cpu8_decode_pkg::MODE_IX2;
          len_d = `LEN_THREE;
          cyc_d = `CYC_IX2; // RULE2
        end
        `HI_IX1: begin
          mode_d = cpu8_decode_pkg::MODE_IX1;
          len_d = `LEN_TWO;
          cyc_d = `CYC_IX1; // RULE2
        end
        default: begin
          mode_d = cpu8_decode_pkg::MODE_IX;
          len_d = `LEN_ONE;
          cyc_d = `CYC_IX; // RULE2
        end
      endcase
      unique case (lo) // RULE1
        4'h0: begin
          oper_d = cpu8_decode_pkg::OP_SUB;
          dif = sub8(acc_i, operand_i, 1'b0);
          res_d = dif[7:0];
          c_d = dif[8];
          acc_wr_d = 1'b1;
          fwr_d = 4'h7;
        end
        4'h1: begin
          oper_d = cpu8_decode_pkg::OP_CMP;
          dif = sub8(acc_i, operand_i, 1'b0);
          res_d = dif[7:0];
          c_d = dif[8];
          fwr_d = 4'h7;
        end
        4'h2: begin
          oper_d = cpu8_decode_pkg::OP_SBC;
          dif = sub8(acc_i, operand_i, flag_carry_i); // RULE4
          res_d = dif[7:0];
          c_d = dif[8];
          acc_wr_d = 1'b1; // RULE4
          fwr_d = 4'h7;
        end
        4'h3: begin
          oper_d = cpu8_decode_pkg::OP_CPX;
          dif = sub8(idx_i, operand_i, 1'b0); // RULE3
          res_d = dif[7:0];
          c_d = dif[8];
          fwr_d = 4'h7;
        end
        4'h4: begin
          oper_d = cpu8_decode_pkg::OP_AND;
          res_d = acc_i & operand_i;
          acc_wr_d = 1'b1;
          fwr_d = 4'h6;
        end
        4'h5: begin
          oper_d = cpu8_decode_pkg::OP_BIT;
          res_d = acc_i & operand_i; // RULE6
          fwr_d = 4'h6;
        end
        4'h6: begin
          oper_d = cpu8_decode_pkg::OP_LDA;
          res_d = operand_i;
          acc_wr_d = 1'b1;
          fwr_d = 4'h6;
        end
        4'h7: begin
          oper_d = cpu8_decode_pkg::OP_STA;
          res_d = acc_i;
          mem_wr_d = 1'b1;
          fwr_d = 4'h6;
        end
        4'h8: begin
          oper_d = cpu8_decode_pkg::OP_EOR;
          res_d = acc_i ^ operand_i;
          acc_wr_d = 1'b1;
          fwr_d = 4'h6;
        end
        4'h9: begin
          oper_d = cpu8_decode_pkg::OP_ADC;
          sum = add8(acc_i, operand_i, flag_carry_i); // RULE5
          res_d = sum[7:0];
          c_d = sum[8];
          h_d = sum[9]; // RULE16
          acc_wr_d = 1'b1; // RULE5
          fwr_d = 4'hf;
        end
        4'ha: begin
          oper_d = cpu8_decode_pkg::OP_ORA;
          res_d = acc_i | operand_i;
          acc_wr_d = 1'b1;
          fwr_d = 4'h6;
        end
        4'hb: begin
          oper_d = cpu8_decode_pkg::OP_ADD;
          sum = add8(acc_i, operand_i, 1'b0);
          res_d = sum[7:0];
          c_d = sum[8];
          h_d = sum[9]; // RULE16
          acc_wr_d = 1'b1;
          fwr_d = 4'hf;
        end
        4'hc: begin
          oper_d = cpu8_decode_pkg::OP_JMP;
          cyc_d = cyc_d - `CYC_JUMP_LESS; // RULE19
        end
        4'hd: begin
          oper_d = cpu8_decode_pkg::OP_JSR;
          cyc_d = cyc_d + `CYC_CALL_EXTRA; // RULE19
        end
        4'he: begin
          oper_d = cpu8_decode_pkg::OP_LDX;
          res_d = operand_i;
          idx_wr_d = 1'b1;
          fwr_d = 4'h6;
        end
        default: begin
          oper_d = cpu8_decode_pkg::OP_STX;
          res_d = idx_i;
          mem_wr_d = 1'b1;
          fwr_d = 4'h6;
        end
      endcase
      if (lo == 4'h7 || lo == 4'hf) begin
        cyc_d = cyc_d + `CYC_STORE_EXTRA; // RULE18
      end
      if (opcode_i == `OPC_CALL_REL) begin
        oper_d = cpu8_decode_pkg::OP_CALL_REL; // RULE19
        mode_d = cpu8_decode_pkg::MODE_REL;
        cyc_d = `CYC_CALL_REL;
      end else if (hi == `HI_IMM && (lo == 4'h7 || lo == 4'hc || lo == 4'hf)) begin
        ok_d = 1'b0; // RULE18
        acc_wr_d = 1'b0;
        idx_wr_d = 1'b0;
        mem_wr_d = 1'b0;
        fwr_d = 4'h0;
      end
    end else if (hi == `HI_REL) begin
      ok_d = 1'b1;
      oper_d = cpu8_decode_pkg::OP_BRANCH;
      mode_d = cpu8_decode_pkg::MODE_REL;
      len_d = `LEN_TWO; // RULE7
      cyc_d = `CYC_REL; // RULE7
      unique case (lo[3:1])
        3'h0: taken_d = 1'b1; // RULE7
        3'h1: taken_d = ~(flag_carry_i | flag_zero_i); // RULE8
        3'h2: taken_d = ~flag_carry_i; // RULE9
        3'h3: taken_d = ~flag_zero_i;
        3'h4: taken_d = ~flag_half_i; // RULE10
        3'h5: taken_d = ~flag_neg_i;
        3'h6: taken_d = ~flag_mask_i; // RULE11
        default: taken_d = ~irq_sync_q; // RULE12
      endcase
      // The odd opcode of each pair tests the opposite sense.
      taken_d = taken_d ^ lo[0]; // RULE7 RULE8 RULE9 RULE10 RULE11 RULE12
    end else if (hi == `HI_BITOP) begin
      ok_d = 1'b1;
      oper_d = lo[0] ? cpu8_decode_pkg::OP_TEST_ZERO : cpu8_decode_pkg::OP_TEST_ONE;
      mode_d = cpu8_decode_pkg::MODE_BTB;
      len_d = `LEN_THREE; // RULE13 RULE14
      cyc_d = `CYC_BIT;
      taken_d = tbit ^ lo[0]; // RULE13 RULE14
      c_d = tbit; // RULE15
      fwr_d = 4'h1;
    end else if (hi == `HI_BITSC) begin
      ok_d = 1'b1;
      oper_d = lo[0] ? cpu8_decode_pkg::OP_CLR_BIT : cpu8_decode_pkg::OP_SET_BIT;
      mode_d = cpu8_decode_pkg::MODE_BSC;
      len_d = `LEN_TWO; // RULE17
      cyc_d = `CYC_BIT; // RULE17
      res_d = operand_i;
      res_d[opcode_i[3:1]] = ~lo[0];
      mem_wr_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Write enables are qualified by the strobe so a held opcode cannot repeat a write.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dec_valid_o <= 1'b0;
      opcode_o <= 8'h00;
      supported_o <= 1'b0;
      mode_o <= cpu8_decode_pkg::MODE_NONE;
      oper_o <= cpu8_decode_pkg::OP_NONE;
      length_o <= 2'h0;
      cycles_o <= 4'h0;
      branch_taken_o <= 1'b0;
      result_o <= 8'h00;
      acc_wr_o <= 1'b0;
      idx_wr_o <= 1'b0;
      mem_wr_o <= 1'b0;
      flag_wr_o <= 4'h0;
      half_o <= 1'b0;
      neg_o <= 1'b0;
      zero_o <= 1'b0;
      carry_o <= 1'b0;
    end else begin
      dec_valid_o <= op_valid_i;
      opcode_o <= opcode_i;
      supported_o <= ok_d;
      mode_o <= mode_d;
      oper_o <= oper_d;
      length_o <= len_d;
      cycles_o <= cyc_d;
      branch_taken_o <= taken_d;
      result_o <= res_d;
      acc_wr_o <= acc_wr_d & op_valid_i;
      idx_wr_o <= idx_wr_d & op_valid_i;
      mem_wr_o <= mem_wr_d & op_valid_i;
      flag_wr_o <= fwr_d & {4{op_valid_i}};
      half_o <= h_d;
      neg_o <= res_d[7];
      zero_o <= (res_d == 8'h00);
      carry_o <= c_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rel_timing_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE7
    dec_valid_o && opcode_o[7:4] == 4'h2 |-> length_o == 2'h2 && cycles_o == 4'h3
      && (opcode_o != 8'h20 || branch_taken_o) && (opcode_o != 8'h21 || !branch_taken_o))
    else $error("Relative branch timing or fixed sense wrong.");

  higher_branch_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE8
    dec_valid_o && opcode_o[7:1] == 7'h11 |->
      branch_taken_o == (!($past(flag_carry_i) | $past(flag_zero_i)) ^ opcode_o[0]))
    else $error("Unsigned higher branch decision wrong.");

  carry_branch_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE9
    dec_valid_o && opcode_o[7:1] == 7'h12 |->
      branch_taken_o == ($past(flag_carry_i) == opcode_o[0]))
    else $error("Carry branch decision wrong.");

  half_branch_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE10
    dec_valid_o && opcode_o[7:1] == 7'h14 |->
      branch_taken_o == ($past(flag_half_i) == opcode_o[0]))
    else $error("Half carry branch decision wrong.");

  mask_branch_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11
    dec_valid_o && opcode_o[7:1] == 7'h16 |->
      branch_taken_o == ($past(flag_mask_i) == opcode_o[0]))
    else $error("Interrupt mask branch decision wrong.");

  irq_branch_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE12
    dec_valid_o && opcode_o[7:1] == 7'h17 && $past(rst_i, 3) == 1'b0 |->
      branch_taken_o == ($past(irq_pin_i, 3) == opcode_o[0]))
    else $error("Interrupt pin branch decision wrong.");

  bit_branch_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE13
    dec_valid_o && opcode_o[7:4] == 4'h0 |-> length_o == 2'h3 && cycles_o == 4'h5
      && carry_o == $past(operand_i[opcode_i[3:1]])
      && branch_taken_o == (carry_o ^ opcode_o[0]))
    else $error("Bit test branch wrong.");

  bit_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE17
    dec_valid_o && opcode_o[7:4] == 4'h1 |-> length_o == 2'h2 && cycles_o == 4'h5
      && result_o[opcode_o[3:1]] == !opcode_o[0])
    else $error("Bit set or clear wrong.");

  add_carry_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE5
    dec_valid_o && opcode_o == 8'ha9 |-> acc_wr_o
      && {carry_o, result_o} == {1'b0, $past(acc_i)} + {1'b0, $past(operand_i)}
        + {8'h00, $past(flag_carry_i)})
    else $error("Add with carry result wrong.");

  compare_index_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE3
    dec_valid_o && opcode_o[3:0] == 4'h3 && opcode_o[7:4] >= 4'ha |->
      !idx_wr_o && !acc_wr_o && flag_wr_o == 4'h7
      && result_o == $past(idx_i) - $past(operand_i))
    else $error("Index compare wrong.");

  bit_test_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE6
    dec_valid_o && opcode_o[3:0] == 4'h5 && opcode_o[7:4] >= 4'ha |->
      !acc_wr_o && result_o == ($past(acc_i) & $past(operand_i)))
    else $error("Bit test altered accumulator.");

  store_timing_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE18
    dec_valid_o && opcode_o == 8'hb7 |-> cycles_o == 4'h4 && length_o == 2'h2
      && mem_wr_o && supported_o)
    else $error("Direct store timing wrong.");

  read_timing_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE2
    dec_valid_o && opcode_o == 8'hd1 |-> length_o == 2'h3 && cycles_o == 4'h5
      && mode_o == cpu8_decode_pkg::MODE_IX2)
    else $error("Indexed 16-bit compare timing wrong.");

  call_rel_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE19
    dec_valid_o && opcode_o == 8'had |-> length_o == 2'h2 && cycles_o == 4'h6
      && oper_o == cpu8_decode_pkg::OP_CALL_REL)
    else $error("Relative call timing wrong.");

endmodule : cpu8_opcode_decode_timing

/* File: testbench/cpu8_opcode_decode_timing_test.sv */
// Self-checking testbench for the opcode decoder.
`timescale 1ns/10ps

module cpu8_opcode_decode_timing_test;

  // ----------------------------------------------------------------
  // Signals and expectation queue
  // ----------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic op_valid_i = 1'b0;
  logic [7:0] opcode_i = 8'h00;
  logic [7:0] operand_i = 8'h00;
  logic [7:0] acc_i = 8'h00;
  logic [7:0] idx_i = 8'h00;
  logic [4:0] flags_in = 5'h00;
  logic irq_pin_i = 1'b1;
  logic pin_lvl = 1'b1;
  logic dec_valid_o, supported_o, branch_taken_o, acc_wr_o, idx_wr_o, mem_wr_o;
  logic half_o, neg_o, zero_o, carry_o;
  logic [7:0] opcode_o, result_o;
  logic [1:0] length_o;
  logic [3:0] cycles_o, flag_wr_o;
  cpu8_decode_pkg::mode_t mode_o;
  cpu8_decode_pkg::oper_t oper_o;
  int fails = 0;
  int num_checks = 0;
  int seed_val;

  typedef struct {
    logic [7:0] opc;
    logic sup, br, chk_br, chk_res, chk_mo, chk_lc;
    logic [1:0] len;
    logic [3:0] cyc, flg, fmask, mode;
    logic [7:0] res;
    logic [2:0] wr;
    logic [4:0] oper;
  } exp_t;
  exp_t exp_q[$];
  exp_t mon_e;

  localparam cpu8_decode_pkg::oper_t oper_tab [16] = '{
    cpu8_decode_pkg::OP_SUB, cpu8_decode_pkg::OP_CMP, cpu8_decode_pkg::OP_SBC,
    cpu8_decode_pkg::OP_CPX, cpu8_decode_pkg::OP_AND, cpu8_decode_pkg::OP_BIT,
    cpu8_decode_pkg::OP_LDA, cpu8_decode_pkg::OP_STA, cpu8_decode_pkg::OP_EOR,
    cpu8_decode_pkg::OP_ADC, cpu8_decode_pkg::OP_ORA, cpu8_decode_pkg::OP_ADD,
    cpu8_decode_pkg::OP_JMP, cpu8_decode_pkg::OP_JSR, cpu8_decode_pkg::OP_LDX,
    cpu8_decode_pkg::OP_STX};

  always #12.5 mclk_i = ~mclk_i;

  cpu8_opcode_decode_timing i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .opcode_i(opcode_i),
    .operand_i(operand_i), .acc_i(acc_i), .idx_i(idx_i), .flag_half_i(flags_in[4]),
    .flag_mask_i(flags_in[3]), .flag_neg_i(flags_in[2]), .flag_zero_i(flags_in[1]),
    .flag_carry_i(flags_in[0]), .irq_pin_i(irq_pin_i), .dec_valid_o(dec_valid_o),
    .opcode_o(opcode_o), .supported_o(supported_o), .mode_o(mode_o), .oper_o(oper_o),
    .length_o(length_o), .cycles_o(cycles_o), .branch_taken_o(branch_taken_o),
    .result_o(result_o), .acc_wr_o(acc_wr_o), .idx_wr_o(idx_wr_o), .mem_wr_o(mem_wr_o),
    .flag_wr_o(flag_wr_o), .half_o(half_o), .neg_o(neg_o), .zero_o(zero_o),
    .carry_o(carry_o)
  );

  // ----------------------------------------------------------------
  // Reference model, flags are {half, mask, neg, zero, carry}
  // ----------------------------------------------------------------
  function automatic exp_t model(input logic [7:0] op, input logic [7:0] m,
                                 input logic [7:0] a, input logic [7:0] x,
                                 input logic [4:0] f, input logic pin);
    exp_t e;
    logic [3:0] hi;
    logic [3:0] lo;
    logic [8:0] s;
    logic [7:0] opnd;
    logic cin;
    e = '{default: '0};
    hi = op[7:4];
    lo = op[3:0];
    e.opc = op;
    e.chk_lc = 1'b1;
    e.chk_mo = 1'b1;
    if (hi >= 4'ha) begin
      e.sup = 1'b1;
      e.oper = oper_tab[lo];
      case (hi)
        4'ha: begin e.len = 2'h2; e.cyc = 4'h2; e.mode = cpu8_decode_pkg::MODE_IMM; end
        4'hb: begin e.len = 2'h2; e.cyc = 4'h3; e.mode = cpu8_decode_pkg::MODE_DIR; end
        4'hc: begin e.len = 2'h3; e.cyc = 4'h4; e.mode = cpu8_decode_pkg::MODE_EXT; end
        4'hd: begin e.len = 2'h3; e.cyc = 4'h5; e.mode = cpu8_decode_pkg::MODE_IX2; end
        4'he: begin e.len = 2'h2; e.cyc = 4'h4; e.mode = cpu8_decode_pkg::MODE_IX1; end
        default: begin e.len = 2'h1; e.cyc = 4'h3; e.mode = cpu8_decode_pkg::MODE_IX; end
      endcase
      if (lo == 4'h7 || lo == 4'hf) e.cyc = e.cyc + 4'h1;
      if (lo == 4'hc) e.cyc = e.cyc - 4'h1;
      if (lo == 4'hd) e.cyc = e.cyc + 4'h2;
      opnd = (lo == 4'h3 || lo == 4'hf) ? x : a;
      cin = (lo == 4'h2 || lo == 4'h9) ? f[0] : 1'b0;
      e.fmask = 4'h6;
      e.chk_res = 1'b1;
      case (lo)
        4'h0, 4'h1, 4'h2, 4'h3: begin
          s = {1'b0, opnd} - {1'b0, m} - {8'h00, cin};
          e.res = s[7:0];
          e.flg[0] = s[8];
          e.fmask = 4'h7;
          e.wr = (lo == 4'h0 || lo == 4'h2) ? 3'h4 : 3'h0;
        end
        4'h4, 4'h5: begin e.res = a & m; e.wr = (lo == 4'h4) ? 3'h4 : 3'h0; end
        4'h6: begin e.res = m; e.wr = 3'h4; end
        4'he: begin e.res = m; e.wr = 3'h2; end
        4'h7, 4'hf: begin e.res = opnd; e.wr = 3'h1; end
        4'h8: begin e.res = a ^ m; e.wr = 3'h4; end
        4'ha: begin e.res = a | m; e.wr = 3'h4; end
        4'h9, 4'hb: begin
          s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
          e.res = s[7:0];
          e.flg[0] = s[8];
          e.flg[3] = ({1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin}) > 5'h0f;
          e.fmask = 4'hf;
          e.wr = 3'h4;
        end
        default: begin e.fmask = 4'h0; e.chk_res = 1'b0; end
      endcase
      if (lo == 4'h1 || lo == 4'h3 || lo == 4'h5) e.chk_res = 1'b0;
      if (op == 8'had) begin
        e.len = 2'h2;
        e.cyc = 4'h6;
        e.mode = cpu8_decode_pkg::MODE_REL;
        e.oper = cpu8_decode_pkg::OP_CALL_REL;
      end
      if (op == 8'ha7 || op == 8'hac || op == 8'haf) begin
        e.sup = 1'b0;
        e.wr = 3'h0;
        e.fmask = 4'h0;
        e.chk_res = 1'b0;
      end
    end else if (hi == 4'h2) begin
      e.sup = 1'b1;
      e.len = 2'h2;
      e.cyc = 4'h3;
      e.chk_br = 1'b1;
      e.mode = cpu8_decode_pkg::MODE_REL;
      e.oper = cpu8_decode_pkg::OP_BRANCH;
      case (lo)
        4'h0: e.br = 1'b1;
        4'h1: e.br = 1'b0;
        4'h2: e.br = ~(f[0] | f[1]);
        4'h3: e.br = f[0] | f[1];
        4'h4: e.br = ~f[0];
        4'h5: e.br = f[0];
        4'h6: e.br = ~f[1];
        4'h7: e.br = f[1];
        4'h8: e.br = ~f[4];
        4'h9: e.br = f[4];
        4'ha: e.br = ~f[2];
        4'hb: e.br = f[2];
        4'hc: e.br = ~f[3];
        4'hd: e.br = f[3];
        4'he: e.br = ~pin;
        default: e.br = pin;
      endcase
    end else if (hi == 4'h0) begin
      e.sup = 1'b1;
      e.len = 2'h3;
      e.cyc = 4'h5;
      e.chk_br = 1'b1;
      e.mode = cpu8_decode_pkg::MODE_BTB;
      e.oper = op[0] ? cpu8_decode_pkg::OP_TEST_ZERO : cpu8_decode_pkg::OP_TEST_ONE;
      e.br = op[0] ^ m[op[3:1]];
      e.flg[0] = m[op[3:1]];
      e.fmask = 4'h1;
    end else if (hi == 4'h1) begin
      e.sup = 1'b1;
      e.len = 2'h2;
      e.cyc = 4'h5;
      e.chk_res = 1'b1;
      e.res = op[0] ? (m & ~(8'h01 << op[3:1])) : (m | (8'h01 << op[3:1]));
      e.mode = cpu8_decode_pkg::MODE_BSC;
      e.oper = op[0] ? cpu8_decode_pkg::OP_CLR_BIT : cpu8_decode_pkg::OP_SET_BIT;
      e.wr = 3'h1;
    end
    e.flg[2] = e.res[7];
    e.flg[1] = (e.res == 8'h00);
    return e;
  endfunction : model

  // ----------------------------------------------------------------
  // Driver, monitor and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    num_checks++;
    if (seen !== expv) begin
      fails++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask : check

  task automatic drive(input logic [7:0] op, input logic [7:0] m, input logic [7:0] a,
                       input logic [7:0] x, input logic [4:0] f, input logic vld);
    @(posedge mclk_i);
    #1;
    op_valid_i = vld;
    opcode_i = op;
    operand_i = m;
    acc_i = a;
    idx_i = x;
    flags_in = f;
    irq_pin_i = pin_lvl;
    if (vld) exp_q.push_back(model(op, m, a, x, f, pin_lvl));
  endtask : drive

  task automatic drive_rand(input logic [7:0] op, input logic vld);
    drive(op, 8'($urandom), 8'($urandom), 8'($urandom), 5'($urandom), vld);
  endtask : drive_rand

  always @(posedge mclk_i) begin
    #2;
    if (dec_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        mon_e = exp_q.pop_front();
        check(16'(opcode_o), 16'(mon_e.opc));
        check(16'(supported_o), 16'(mon_e.sup));
        if (mon_e.chk_lc) check({10'h0, length_o, cycles_o}, {10'h0, mon_e.len, mon_e.cyc});
        if (mon_e.chk_mo) check({7'h0, mode_o, oper_o}, {7'h0, mon_e.mode, mon_e.oper});
        if (mon_e.chk_br) check(16'(branch_taken_o), 16'(mon_e.br));
        check(16'({acc_wr_o, idx_wr_o, mem_wr_o}), 16'(mon_e.wr));
        check(16'(flag_wr_o), 16'(mon_e.fmask));
        check(16'({half_o, neg_o, zero_o, carry_o} & mon_e.fmask),
              16'(mon_e.flg & mon_e.fmask));
        if (mon_e.chk_res) check(16'(result_o), 16'(mon_e.res));
      end
    end else if (rst_i === 1'b0) begin
      check(16'({acc_wr_o, idx_wr_o, mem_wr_o, flag_wr_o}), 16'h0000);
    end
  end

  // ----------------------------------------------------------------
  // Closing and watchdog
  // ----------------------------------------------------------------
  task automatic final_report();
    if (exp_q.size() != 0) fails++;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #(25 * 3000);
    fails++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed_val = $urandom(32'h1b56);
    repeat (12) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    drive(8'ha9, 8'h01, 8'h0f, 8'h00, 5'h00, 1'b1);
    for (int hi = 10; hi < 16; hi++) begin
      for (int lo = 0; lo < 16; lo++) drive_rand({4'(hi), 4'(lo)}, 1'b1);
    end
    $display("test memory group done");
    // The pin passes a synchroniser, so it settles before branches use it.
    for (int p = 0; p < 2; p++) begin
      pin_lvl = p[0];
      repeat (4) drive_rand(8'h9d, 1'b0);
      for (int k = 0; k < 4; k++) begin
        for (int lo = 0; lo < 16; lo++) drive_rand({4'h2, 4'(lo)}, 1'b1);
      end
    end
    $display("test branch group done");
    for (int k = 0; k < 3; k++) begin
      for (int op = 0; op < 32; op++) drive_rand(8'(op), 1'b1);
    end
    $display("test bit group done");
    drive_rand(8'had, 1'b1);
    drive_rand(8'h42, 1'b1);
    drive_rand(8'h9d, 1'b1);
    drive_rand(8'ha9, 1'b0);
    drive_rand(8'hb7, 1'b0);
    drive_rand(8'hbb, 1'b1);
    repeat (3) drive_rand(8'h00, 1'b0);
    $display("test odd opcodes done");
    final_report();
  end

endmodule : cpu8_opcode_decode_timing_test
